// ### hdl/uto_regs.svh
// Register offsets, field positions, reset values and counts of the
// serial port test and observe block. Definitions only.
`ifndef UTO_REGS_SVH
`define UTO_REGS_SVH

`define UTO_OFF_IER 8'h04
`define UTO_OFF_FCR 8'h08
`define UTO_OFF_LCR 8'h0C
`define UTO_OFF_MCR 8'h10
`define UTO_OFF_MSR 8'h18
`define UTO_OFF_TMODE 8'h20
`define UTO_OFF_OVR 8'h24
`define UTO_OFF_RAW 8'h28
`define UTO_OFF_SEEN 8'h2C
`define UTO_OFF_OUTLVL 8'h30
`define UTO_OFF_RDYLVL 8'h3C
`define UTO_OFF_DIV 8'h40

`define UTO_IER_PTE_BIT 7
`define UTO_LCR_STICK_BIT 5
`define UTO_MCR_LOOP_BIT 4
`define UTO_MCR_AFE_BIT 5

`define UTO_RST_SEEN 4'h2
`define UTO_RST_OUTLVL 5'h0F
`define UTO_RST_RDYLVL 3'h2
`define UTO_RST_OVR 4'h0
`define UTO_RST_DIV 16'h0000

`define UTO_OVERSAMPLE 16

`endif

// ### hdl/uto_pkg.sv
// Types shared by the serial port test and observe block.
// Assumes the constants header is included alongside.
package uto_pkg;
  typedef enum logic [1:0] {
    UTO_RESP_OKAY = 2'h0,
    UTO_RESP_SLVERR = 2'h2
  } uto_resp_t;
  // Modem input bit order: [3] carrier, [2] ring, [1] set ready, [0] cts
  typedef logic [3:0] uto_modem_t;
endpackage

// ### hdl/uto_top.sv
// Test and observe logic of the serial port, with an AXI4-Lite slave.
// Assumes mclk-clocked peers drive the ready and interrupt levels; modem
// pins arrive asynchronously.
`timescale 1ns/1ps
`include "uto_regs.svh"

module uto_top
  import uto_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // AXI4-Lite write
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Modem pins, low is active
  input wire logic [3:0] modem_pin_n,
  output logic request_to_send_n,
  // Levels from the transmit, receive and interrupt logic
  input wire logic transmit_ready_out,
  input wire logic receive_ready_out,
  input wire logic interrupt_out,
  // Controls for the rest of the port
  output logic prog_tx_empty_irq_enable,
  output logic [1:0] tx_trigger_level,
  output logic auto_flow_enable,
  output logic loopback_enable,
  output logic baud_clock_output
);

  // Bus handshake state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_have_q, w_have_q;
  logic [AW-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wlane_q;
  uto_resp_t bresp_q, rresp_q;
  logic [31:0] rdata_q;
  // Control registers
  logic [7:0] ier_q, lcr_q, mcr_q;
  logic [1:0] trig_q;
  logic test_q;
  uto_modem_t ovr_q;
  logic [15:0] div_q, cnt_q;
  logic baud_q, rts_n_q;
  // Observed state
  uto_modem_t raw_s1_q, raw_s2_q, seen_q, seen_d;
  logic [3:0] flag_q, flag_set;
  logic [4:0] outlvl_q;
  logic [2:0] rdylvl_q;
  logic started_q;

  // Write decode
  wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
  wire [7:0] wa = awaddr_q[7:0];
  wire wa_hi_ok = (awaddr_q >> 8) == '0;
  wire wr_ier = wa_hi_ok & (wa == `UTO_OFF_IER);
  wire wr_fcr = wa_hi_ok & (wa == `UTO_OFF_FCR);
  wire wr_lcr = wa_hi_ok & (wa == `UTO_OFF_LCR);
  wire wr_mcr = wa_hi_ok & (wa == `UTO_OFF_MCR);
  wire wr_tm = wa_hi_ok & (wa == `UTO_OFF_TMODE);
  wire wr_ovr = wa_hi_ok & (wa == `UTO_OFF_OVR);
  wire wr_div = wa_hi_ok & (wa == `UTO_OFF_DIV);
  wire wr_ro = wa_hi_ok & ((wa == `UTO_OFF_MSR) | (wa == `UTO_OFF_RAW) |
    (wa == `UTO_OFF_SEEN) | (wa == `UTO_OFF_OUTLVL) |
    (wa == `UTO_OFF_RDYLVL));
  wire wr_hit = wr_ier | wr_fcr | wr_lcr | wr_mcr | wr_tm | wr_ovr |
    wr_div | wr_ro;
  // Only the low byte lane carries register data
  wire wr_en = wr_go & wlane_q;

  // Read decode
  wire rd_go = s_axi_arvalid & arready_q;
  wire [7:0] ra = s_axi_araddr[7:0];
  wire ra_hi_ok = (s_axi_araddr >> 8) == '0;
  wire loop = mcr_q[`UTO_MCR_LOOP_BIT];
  wire [7:0] msr_view = {loop & ~seen_q[3], loop & ~seen_q[2],
    loop & ~seen_q[1], ~seen_q[0], flag_q};
  wire rd_msr = rd_go & ra_hi_ok & (ra == `UTO_OFF_MSR);
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = ra_hi_ok;
    case (ra)
      `UTO_OFF_IER: rd_mux[7:0] = ier_q;
      `UTO_OFF_FCR: rd_mux[5:4] = trig_q;
      `UTO_OFF_LCR: rd_mux[7:0] = lcr_q;
      `UTO_OFF_MCR: rd_mux[7:0] = mcr_q;
      `UTO_OFF_MSR: rd_mux[7:0] = msr_view;
      `UTO_OFF_TMODE: rd_mux[0] = test_q;
      `UTO_OFF_OVR: rd_mux[3:0] = ovr_q;
      `UTO_OFF_RAW: rd_mux[3:0] = raw_s2_q;
      `UTO_OFF_SEEN: rd_mux[3:0] = seen_q;
      `UTO_OFF_OUTLVL: rd_mux[4:0] = outlvl_q;
      `UTO_OFF_RDYLVL: rd_mux[2:0] = rdylvl_q;
      `UTO_OFF_DIV: rd_mux[15:0] = div_q;
      default: rd_hit = 1'b0;
    endcase
    if (!ra_hi_ok) begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= UTO_RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awaddr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        wdata_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? UTO_RESP_OKAY : UTO_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= UTO_RESP_OKAY;
    end else if (rd_go) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? UTO_RESP_OKAY : UTO_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Control registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ier_q <= 8'h00;
      trig_q <= 2'h0;
      lcr_q <= 8'h00;
      mcr_q <= 8'h00;
      test_q <= 1'b0;
      ovr_q <= `UTO_RST_OVR;
      div_q <= `UTO_RST_DIV;
    end else if (wr_en) begin
      if (wr_ier) ier_q <= wdata_q;
      if (wr_fcr) trig_q <= wdata_q[5:4];
      // Stick parity is not built, so its bit is held at zero
      if (wr_lcr) lcr_q <= wdata_q & ~(8'h01 << `UTO_LCR_STICK_BIT);
      if (wr_mcr) mcr_q <= {2'h0, wdata_q[5:0]};
      if (wr_tm) test_q <= wdata_q[0];
      if (wr_ovr) ovr_q <= wdata_q[3:0];
      // Divisor is source clock / bit rate / 16; a write sets only the low half
      if (wr_div) div_q[7:0] <= wdata_q;
    end else if (wr_go && wr_div && s_axi_wstrb[1]) begin
      div_q <= div_q;
    end
  end

  // Pin synchroniser; only the second stage is looked at
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      raw_s1_q <= 4'hF;
      raw_s2_q <= 4'hF;
    end else begin
      raw_s1_q <= modem_pin_n;
      raw_s2_q <= raw_s1_q;
    end
  end

  // Test mode replaces the pins; loopback then ties inputs to outputs
  wire [3:0] pin_eff = test_q ? ovr_q : raw_s2_q;
  assign seen_d = loop ? {~mcr_q[3], ~mcr_q[2], ~mcr_q[0], ~mcr_q[1]}
    : pin_eff;
  // Change flags other than cts only move in loopback
  assign flag_set = {loop & (seen_d[3] ^ seen_q[3]),
    loop & seen_d[2] & ~seen_q[2], loop & (seen_d[1] ^ seen_q[1]),
    seen_d[0] ^ seen_q[0]};
  // Seen resets to a value that idle pins do not show, so the first edge
  // after reset would look like a change; it is not taken as one
  wire [3:0] flag_gated = started_q ? flag_set : 4'h0;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      seen_q <= `UTO_RST_SEEN;
      flag_q <= 4'h0;
      started_q <= 1'b0;
    end else begin
      seen_q <= seen_d;
      started_q <= 1'b1;
      // A change in the read cycle is kept: set beats the read clear
      flag_q <= (rd_msr ? 4'h0 : flag_q) | flag_gated;
    end
  end

  // Baud clock: one pulse per divisor count; zero stops it
  // Only the low divisor byte is writable, which limits the slowest rate
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_q <= 16'h0000;
      baud_q <= 1'b0;
    end else if (div_q == 16'h0000) begin
      cnt_q <= 16'h0000;
      baud_q <= 1'b0;
    end else if (cnt_q >= div_q - 16'h0001) begin
      cnt_q <= 16'h0000;
      baud_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      baud_q <= 1'b0;
    end
  end

  // Level mirrors and outputs; rts pin goes idle in loopback
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      outlvl_q <= `UTO_RST_OUTLVL;
      rdylvl_q <= `UTO_RST_RDYLVL;
      rts_n_q <= 1'b1;
    end else begin
      outlvl_q <= {baud_q, ~mcr_q[3:0]};
      rdylvl_q <= {transmit_ready_out, receive_ready_out,
        interrupt_out};
      rts_n_q <= loop | ~mcr_q[1];
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign request_to_send_n = rts_n_q;
  assign prog_tx_empty_irq_enable = ier_q[`UTO_IER_PTE_BIT];
  assign tx_trigger_level = trig_q;
  assign auto_flow_enable = mcr_q[`UTO_MCR_AFE_BIT];
  assign loopback_enable = mcr_q[`UTO_MCR_LOOP_BIT];
  assign baud_clock_output = baud_q;

  a_test_select: assert property (@(posedge mclk) disable iff (reset)
    wr_en && wr_tm |=> test_q == $past(wdata_q[0]))
    else $error("test mode bit not written");
  a_override_seen: assert property (@(posedge mclk)
    disable iff (reset)
    test_q && !loop |=> seen_q == $past(ovr_q))
    else $error("override not seen in test mode");
  a_raw_read: assert property (@(posedge mclk) disable iff (reset)
    rd_go && ra_hi_ok && ra == `UTO_OFF_RAW |=>
      rvalid_q && rdata_q[3:0] == $past(raw_s2_q))
    else $error("raw read differs from pins");
  // Seen keeps its reset value for one edge, so the check starts after it
  a_normal_follow: assert property (@(posedge mclk)
    disable iff (reset)
    started_q && !test_q && !loop |=> seen_q == $past(raw_s2_q))
    else $error("seen levels differ from raw in normal mode");
  a_out_levels: assert property (@(posedge mclk) disable iff (reset)
    ##1 outlvl_q[3:0] == ~$past(mcr_q[3:0]))
    else $error("output level mirror wrong");
  a_ready_mirror: assert property (@(posedge mclk) disable iff (reset)
    ##2 rdylvl_q == $past({transmit_ready_out, receive_ready_out,
      interrupt_out}, 1))
    else $error("ready level mirror wrong");
  a_loop_only: assert property (@(posedge mclk) disable iff (reset)
    !loop && !flag_q[1] |-> !msr_view[5] ##1 !flag_q[1])
    else $error("set ready status moved outside loopback");
  a_no_stick: assert property (@(posedge mclk) disable iff (reset)
    wr_en && wr_lcr |=> !lcr_q[`UTO_LCR_STICK_BIT])
    else $error("stick parity bit stored");
  a_trig_write: assert property (@(posedge mclk) disable iff (reset)
    wr_en && wr_fcr |=> tx_trigger_level == $past(wdata_q[5:4]))
    else $error("trigger level not stored");
  a_dtr_change: assert property (@(posedge mclk) disable iff (reset)
    loop && seen_d[1] != seen_q[1] |=> flag_q[1])
    else $error("set ready change lost in loopback");
  a_seen_loop: assert property (@(posedge mclk) disable iff (reset)
    loop |=> seen_q[1] == !$past(mcr_q[0]))
    else $error("set ready does not follow terminal ready in loopback");
  a_reset_flags: assert property (@(posedge mclk) disable iff (reset)
    !started_q |=> flag_q == 4'h0)
    else $error("change flag raised by reset");
  a_ovr_write: assert property (@(posedge mclk) disable iff (reset)
    wr_en && wr_ovr |=> ovr_q == $past(wdata_q[3:0]))
    else $error("override bits not stored");

endmodule // uto_top

// ### test/uto_peer.sv
// Serial peer model that drives the modem handshake pins of the port.
// Assumes the bench commands the pin levels and the mclk clock domain.
`timescale 1ns/1ps

module uto_peer (
  // Clock
  input wire logic mclk,
  // Levels asked by the bench, low is active on pin_cmd_n
  input wire logic [3:0] pin_cmd_n,
  input wire logic echo_rts,
  // Request from the port
  input wire logic request_to_send_n,
  // Lines into the port
  output logic [3:0] modem_pin_n
);
  // Peer answers rts on its cts line when echoing, as a flow peer would
  initial modem_pin_n = 4'hF;
  always @(posedge mclk) begin
    modem_pin_n <= echo_rts ? {pin_cmd_n[3:1], request_to_send_n} : pin_cmd_n;
  end
endmodule // uto_peer

// ### test/uart_test_and_signal_observe_bench.sv
// Self-checking bench of the test and observe block over AXI4-Lite.
// Assumes the peer model in uto_peer.sv and a 100 MHz clock.
`timescale 1ns/1ps
`include "uto_regs.svh"

module uart_test_and_signal_observe_bench
  import uto_pkg::*;
;
  logic mclk, reset, echo_rts;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd_v;
  logic [3:0] s_axi_wstrb, pin_cmd_n, p, m;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic transmit_ready_out, receive_ready_out, interrupt_out;
  logic [2:0] lv;
  logic [1:0] rs, t;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, tx_trigger_level;
  wire [31:0] s_axi_rdata;
  wire [3:0] modem_pin_n;
  wire request_to_send_n, prog_tx_empty_irq_enable, auto_flow_enable;
  wire loopback_enable, baud_clock_output;
  int err_count, num_checks, seed, n, cnt;

  uto_top dut (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .modem_pin_n, .request_to_send_n,
    .transmit_ready_out, .receive_ready_out, .interrupt_out,
    .prog_tx_empty_irq_enable, .tx_trigger_level, .auto_flow_enable,
    .loopback_enable, .baud_clock_output);
  uto_peer peer (.mclk, .pin_cmd_n, .echo_rts, .request_to_send_n,
    .modem_pin_n);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready is registered, so its level at the falling edge is what the
  // next rising edge samples; this keeps the bench free of races
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb, done;
    int i;
    done = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50 && !done; i++) begin
      @(negedge mclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge mclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
      done = hb;
    end
    if (!done) begin
      err_count++;
      give_verdict();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic ha, hr, done;
    int i;
    done = 1'b0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50 && !done; i++) begin
      @(negedge mclk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      rd_v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge mclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) s_axi_rready <= 1'b0;
      done = hr;
    end
    if (!done) begin
      err_count++;
      give_verdict();
    end
  endtask

  // Loopback feeds carrier, ring, set ready, cts from mcr 3, 2, 0, 1
  function automatic logic [31:0] lp_seen(input logic [3:0] c);
    return {28'h0, ~c[3], ~c[2], ~c[0], ~c[1]};
  endfunction

  // Divisor from source clock and bit rate, sixteen samples a bit
  function automatic int div_for(input int hz, input int bps);
    return hz / bps / `UTO_OVERSAMPLE;
  endfunction

  initial begin
    reset = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, echo_rts} = '0;
    {transmit_ready_out, receive_ready_out, interrupt_out} = 3'h2;
    s_axi_wstrb = 4'hF;
    pin_cmd_n = 4'hF;
    seed = 32'h9989;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    rd(`UTO_OFF_OUTLVL);
    chk("out levels", rd_v, 32'h0F);
    for (n = 0; n < 6; n++) begin
      p = 4'($random(seed));
      lv = 3'($random(seed));
      pin_cmd_n <= p;
      {transmit_ready_out, receive_ready_out, interrupt_out} <= lv;
      repeat (5) @(posedge mclk);
      rd(`UTO_OFF_RAW);
      chk("raw", rd_v, {28'h0, p});
      rd(`UTO_OFF_SEEN);
      chk("seen", rd_v, {28'h0, p});
      rd(`UTO_OFF_RDYLVL);
      chk("ready levels", rd_v, {29'h0, lv});
      m = 4'($random(seed));
      wr(`UTO_OFF_OVR, {28'h0, m});
      wr(`UTO_OFF_TMODE, 32'h1);
      rd(`UTO_OFF_SEEN);
      chk("override", rd_v, {28'h0, m});
      rd(`UTO_OFF_RAW);
      chk("raw in test", rd_v, {28'h0, p});
      wr(`UTO_OFF_TMODE, 32'h0);
      m = 4'($random(seed));
      wr(`UTO_OFF_MCR, {27'h1, m});
      chk("loopback", {31'h0, loopback_enable}, 32'h1);
      rd(`UTO_OFF_SEEN);
      chk("loop seen", rd_v, lp_seen(m));
      rd(`UTO_OFF_MSR);
      chk("loop status", rd_v[7:4], {m[3], m[2], m[0], m[1]});
      rd(`UTO_OFF_OUTLVL);
      chk("out levels", rd_v, {28'h0, ~m});
      wr(`UTO_OFF_MCR, {27'h1, m ^ 4'h1});
      rd(`UTO_OFF_MSR);
      chk("set ready change", rd_v[1], 1'b1);
      wr(`UTO_OFF_MCR, {28'h0, m});
      chk("loopback off", {31'h0, loopback_enable}, 32'h0);
      rd(`UTO_OFF_MSR);
      chk("status off loop", rd_v[7:5], 3'h0);
      chk("rts pin", {31'h0, request_to_send_n}, {31'h0, ~m[1]});
    end
    echo_rts <= 1'b1;
    wr(`UTO_OFF_MCR, 32'h2);
    repeat (5) @(posedge mclk);
    rd(`UTO_OFF_RAW);
    chk("cts echo", rd_v[0], 1'b0);
    wr(`UTO_OFF_LCR, 32'hFF);
    chk("write okay", {30'h0, rs}, {30'h0, UTO_RESP_OKAY});
    rd(`UTO_OFF_LCR);
    chk("read okay", {30'h0, rs}, {30'h0, UTO_RESP_OKAY});
    chk("stick parity", rd_v[5], 1'b0);
    t = 2'($random(seed));
    wr(`UTO_OFF_IER, 32'h80);
    wr(`UTO_OFF_FCR, {26'h0, t, 4'h0});
    wr(`UTO_OFF_MCR, 32'h20);
    chk("tx empty en", {31'h0, prog_tx_empty_irq_enable}, 32'h1);
    chk("trigger", {30'h0, tx_trigger_level}, {30'h0, t});
    chk("auto flow", {31'h0, auto_flow_enable}, 32'h1);
    wr(8'h50, 32'h0);
    chk("unmapped write", {30'h0, rs}, {30'h0, UTO_RESP_SLVERR});
    rd(8'h50);
    chk("unmapped read", {30'h0, rs}, {30'h0, UTO_RESP_SLVERR});
    wr(`UTO_OFF_DIV, div_for(100_000_000, 1_562_500));
    repeat (8) @(posedge mclk);
    cnt = 0;
    for (n = 0; n < 40; n++) begin
      @(negedge mclk);
      cnt += int'(baud_clock_output === 1'b1);
    end
    chk("baud pulses", cnt, 40 / div_for(100_000_000, 1_562_500));
    give_verdict();
  end
endmodule // uart_test_and_signal_observe_bench
